// [verilog/startup_pkg.sv]
// Operation
// [RQ1] Ignore host commands for ten seconds
// [RQ2] Host waits out acceptance interval first
// [RQ3] Cold start emits periodic alive status
// [RQ4] Fifteen minutes continuous tracking completes almanac
// [RQ5] No UTC before leap second known
// [RQ6] Host avoids interrupting almanac download
// [RQ7] Survey needs masks, ephemeris, position moved
// [RQ8] Survey done switches to time-only mode
// [RQ9] Up to 78 masked signals tracked
// [RQ10] Only listed constellation combinations accepted
// [RQ11] QZSS only together with GPS
// [RQ12] Any L5 means dual band everywhere
// [RQ13] UTC equals system time minus offsets
// [RQ14] No local time zone applied
// [RQ15] Survey averages fixes, default 2000; the code only counts valid fixes up to the goal
// [RQ16] First fix five satellites, later four
// [RQ17] Time-only: two to align, one keeps
// [RQ18] Mode state readable as status code
package startup_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int HOLDOFF_S = 10;
  localparam int ALMANAC_S = 900;
  localparam int STATUS_MS = 1000;
  localparam int HOLDOFF_CYC = HOLDOFF_S * CLK_HZ;
  // Fifteen minutes of cycles does not fit an int, so the limit is 64 bits and the counter 36 bits
  localparam longint ALMANAC_CYC = longint'(ALMANAC_S) * CLK_HZ;
  localparam int STATUS_CYC = STATUS_MS * (CLK_HZ / 1000);
  localparam int SEC_CYC = CLK_HZ;
  localparam logic [15:0] SURVEY_FIXES_DEF = 16'h07D0;
  localparam logic [6:0] MAX_TRACKED = 7'h4E;
  localparam logic [7:0] LEAP_2017 = 8'h12;
  localparam logic [6:0] SV_FIRST_FIX = 7'h05;
  localparam logic [6:0] SV_LATER_FIX = 7'h04;
  localparam logic [6:0] SV_PPS_ALIGN = 7'h02;
  localparam logic [6:0] SV_PPS_KEEP = 7'h01;
  localparam logic [15:0] MOVE_LIMIT_M = 16'h0064;
  // Constellation enable bit positions
  localparam int C_GPS = 0;
  localparam int C_GAL = 1;
  localparam int C_GLO = 2;
  localparam int C_BDS = 3;
  localparam int C_NAV = 4;
  localparam int C_QZS = 5;
  // Status codes of the mode controller
  localparam logic [2:0] ST_COLD = 3'h0;
  localparam logic [2:0] ST_SURVEY = 3'h1;
  localparam logic [2:0] ST_SUSPEND = 3'h2;
  localparam logic [2:0] ST_TIME_ONLY = 3'h3;
  typedef enum {M_COLD, M_SURVEY, M_SUSPEND, M_TIME} mode_t;
endpackage

// [verilog/constellation_check.sv]
`timescale 1ns/1ps
// Combinational check of a requested constellation and band setup
module constellation_check (
  // Request
  input wire logic [5:0] sys_req,
  input wire logic [5:0] l5_req,
  // Verdict
  output logic accept,
  output logic dual_band
);
  logic [4:0] core;
  logic other_one;

  // Core set ignores QZSS, which rides with GPS only
  always_comb begin
    core = sys_req[4:0];
    other_one = (core == 5'h03) || (core == 5'h05) || (core == 5'h09) ||
                (core == 5'h11);
    accept = (core == 5'h01) || (core == 5'h02) || (core == 5'h04) ||
             (core == 5'h08) || (core == 5'h10) || other_one ||
             (core == 5'h0F); // [RQ10]
    if (sys_req[startup_pkg::C_QZS] && !sys_req[startup_pkg::C_GPS]) begin
      accept = 1'b0; // [RQ11]
    end
    if (sys_req[startup_pkg::C_QZS] && core == 5'h0F) begin
      accept = 1'b0; // Default mix has no QZSS
    end
    // One L5 request on a requested system makes every enabled system dual band
    dual_band = |(l5_req & sys_req); // [RQ12]
  end
endmodule // constellation_check

// [verilog/startup_mode_ctrl.sv]
`timescale 1ns/1ps
module startup_mode_ctrl #(
  parameter int HOLDOFF_CYC = startup_pkg::HOLDOFF_CYC,
  parameter longint ALMANAC_CYC = startup_pkg::ALMANAC_CYC,
  parameter int STATUS_CYC = startup_pkg::STATUS_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Host command strobe
  input wire logic cmd_valid,
  output logic cmd_accept,
  output logic cmd_ready,
  // Constellation request, applied with cfg_write
  input wire logic cfg_write,
  input wire logic [5:0] sys_req,
  input wire logic [5:0] l5_req,
  output logic [5:0] sys_enabled,
  output logic dual_band,
  output logic cfg_reject,
  // Tracking front end, same clock
  input wire logic [6:0] sv_visible,
  input wire logic masks_ok,
  input wire logic ephem_ok,
  input wire logic pos_stored,
  input wire logic [15:0] pos_moved_m,
  input wire logic fix_valid,
  input wire logic leap_rx,
  input wire logic [7:0] leap_s,
  input wire logic [15:0] survey_fixes,
  // Time conversion
  input wire logic [31:0] sys_time_s,
  output logic [31:0] utc_s,
  output logic utc_valid,
  // Status
  output logic [6:0] sv_tracked,
  output logic status_pulse,
  output logic almanac_done,
  output logic pps_aligned,
  output logic [2:0] mode_code
);
  startup_pkg::mode_t mode_r, mode_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic [35:0] alm_r, alm_nxt;
  logic [31:0] stat_r, stat_nxt;
  logic [15:0] fix_r, fix_nxt;
  logic first_r, first_nxt;
  logic ready_r, ready_nxt;
  logic alm_done_r, alm_done_nxt;
  logic leap_ok_r, leap_ok_nxt;
  logic [7:0] leap_r, leap_nxt;
  logic pps_r, pps_nxt;
  logic stat_p_r, stat_p_nxt;
  logic acc_r, acc_nxt;
  logic [5:0] sys_r, sys_nxt;
  logic dual_r, dual_nxt;
  logic rej_r, rej_nxt;
  logic [31:0] utc_r, utc_nxt;
  logic [6:0] trk_r, trk_nxt;
  logic chk_ok, chk_dual;
  logic [15:0] fix_goal;
  logic [6:0] need_sv;
  logic survey_go;

  constellation_check u_chk (
    .sys_req(sys_req),
    .l5_req(l5_req),
    .accept(chk_ok),
    .dual_band(chk_dual)
  );

  // Zero fix count falls back to the default
  assign fix_goal = (survey_fixes == 16'h0000) ?
                    startup_pkg::SURVEY_FIXES_DEF : survey_fixes; // [RQ15]
  assign need_sv = first_r ? startup_pkg::SV_FIRST_FIX :
                   startup_pkg::SV_LATER_FIX; // [RQ16]
  assign survey_go = masks_ok && ephem_ok && (!pos_stored ||
                     pos_moved_m > startup_pkg::MOVE_LIMIT_M); // [RQ7]

  // Power-up holdoff, almanac timer, alive beacon, leap capture
  always_comb begin
    hold_nxt = hold_r;
    ready_nxt = ready_r;
    acc_nxt = 1'b0;
    alm_nxt = alm_r;
    alm_done_nxt = alm_done_r;
    stat_nxt = stat_r + 32'h00000001;
    stat_p_nxt = 1'b0;
    leap_ok_nxt = leap_ok_r;
    leap_nxt = leap_r;
    if (!ready_r) begin
      hold_nxt = hold_r + 32'h00000001;
      if (hold_r >= HOLDOFF_CYC - 1) begin
        ready_nxt = 1'b1; // [RQ1]
      end
    end
    // Early commands are dropped silently, no answer at all
    acc_nxt = cmd_valid && ready_r; // [RQ1]
    // Tracking gap restarts the continuous almanac window
    if (sv_tracked == 7'h00) begin
      alm_nxt = 36'h000000000;
    end else if (!alm_done_r) begin
      alm_nxt = alm_r + 36'h000000001;
      if (alm_r >= ALMANAC_CYC - 1) begin
        alm_done_nxt = 1'b1; // [RQ4]
      end
    end
    if (stat_r >= STATUS_CYC - 1) begin
      stat_nxt = 32'h00000000;
      stat_p_nxt = 1'b1; // [RQ3]
    end
    if (leap_rx && alm_done_r) begin
      leap_ok_nxt = 1'b1; // [RQ5]
      leap_nxt = leap_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hold_r <= 32'h00000000;
      ready_r <= 1'b0;
      acc_r <= 1'b0;
      alm_r <= 36'h000000000;
      alm_done_r <= 1'b0;
      stat_r <= 32'h00000000;
      stat_p_r <= 1'b0;
      leap_ok_r <= 1'b0;
      leap_r <= startup_pkg::LEAP_2017;
    end else begin
      hold_r <= hold_nxt;
      ready_r <= ready_nxt;
      acc_r <= acc_nxt;
      alm_r <= alm_nxt;
      alm_done_r <= alm_done_nxt;
      stat_r <= stat_nxt;
      stat_p_r <= stat_p_nxt;
      leap_ok_r <= leap_ok_nxt;
      leap_r <= leap_nxt;
    end
  end

  // Mode machine: cold, survey, suspended survey, time-only
  always_comb begin
    mode_nxt = mode_r;
    fix_nxt = fix_r;
    first_nxt = first_r;
    pps_nxt = pps_r;
    unique case (mode_r)
      startup_pkg::M_COLD: begin
        if (survey_go) begin
          mode_nxt = startup_pkg::M_SURVEY; // [RQ7]
        end
      end
      startup_pkg::M_SURVEY: begin
        if (sv_tracked < need_sv) begin
          mode_nxt = startup_pkg::M_SUSPEND; // [RQ16]
        end else if (fix_valid) begin
          first_nxt = 1'b0;
          fix_nxt = fix_r + 16'h0001;
          if (fix_r + 16'h0001 >= fix_goal) begin
            mode_nxt = startup_pkg::M_TIME; // [RQ8]
          end
        end
      end
      startup_pkg::M_SUSPEND: begin
        if (sv_tracked >= need_sv) begin
          mode_nxt = startup_pkg::M_SURVEY; // [RQ16]
        end
      end
      startup_pkg::M_TIME: begin
        // Alignment needs two, is held by one, lost at zero
        if (!pps_r && sv_tracked >= startup_pkg::SV_PPS_ALIGN) begin
          pps_nxt = 1'b1; // [RQ17]
        end else if (pps_r && sv_tracked < startup_pkg::SV_PPS_KEEP) begin
          pps_nxt = 1'b0; // [RQ17]
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mode_r <= startup_pkg::M_COLD;
      fix_r <= 16'h0000;
      first_r <= 1'b1;
      pps_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      fix_r <= fix_nxt;
      first_r <= first_nxt;
      pps_r <= pps_nxt;
    end
  end

  // Configuration, tracked count clamp and UTC output
  always_comb begin
    sys_nxt = sys_r;
    dual_nxt = dual_r;
    rej_nxt = 1'b0;
    if (cfg_write && ready_r) begin
      if (chk_ok) begin
        sys_nxt = sys_req; // [RQ10]
        dual_nxt = chk_dual; // [RQ12]
      end else begin
        rej_nxt = 1'b1; // [RQ11]
      end
    end
    trk_nxt = masks_ok ? sv_visible : 7'h00; // [RQ9]
    if (trk_nxt > startup_pkg::MAX_TRACKED) begin
      trk_nxt = startup_pkg::MAX_TRACKED; // [RQ9]
    end
    // Plain UTC, no zone shift; sub-microsecond steering is below 1 s
    utc_nxt = sys_time_s - {24'h000000, leap_r}; // [RQ13] [RQ14]
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sys_r <= 6'h0F;
      dual_r <= 1'b1;
      rej_r <= 1'b0;
      trk_r <= 7'h00;
      utc_r <= 32'h00000000;
    end else begin
      sys_r <= sys_nxt;
      dual_r <= dual_nxt;
      rej_r <= rej_nxt;
      trk_r <= trk_nxt;
      utc_r <= utc_nxt;
    end
  end

  // Output mapping
  assign cmd_ready = ready_r;
  assign cmd_accept = acc_r;
  assign sys_enabled = sys_r;
  assign dual_band = dual_r;
  assign cfg_reject = rej_r;
  assign sv_tracked = trk_r;
  assign status_pulse = stat_p_r;
  assign almanac_done = alm_done_r;
  assign pps_aligned = pps_r;
  assign utc_s = utc_r;
  assign utc_valid = leap_ok_r; // [RQ5]

  always_comb begin
    unique case (mode_r)
      startup_pkg::M_COLD: mode_code = startup_pkg::ST_COLD;
      startup_pkg::M_SURVEY: mode_code = startup_pkg::ST_SURVEY;
      startup_pkg::M_SUSPEND: mode_code = startup_pkg::ST_SUSPEND;
      startup_pkg::M_TIME: mode_code = startup_pkg::ST_TIME_ONLY; // [RQ18]
    endcase
  end

  // Checks
  property p_holdoff;
    @(posedge mclk) disable iff (!resetn) !ready_r |=> !cmd_accept;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("early accept"); // [RQ1]
  property p_utc;
    @(posedge mclk) disable iff (!resetn) utc_valid |-> almanac_done;
  endproperty
  a_utc: assert property (p_utc) else $error("utc early"); // [RQ5]
  property p_time;
    @(posedge mclk) disable iff (!resetn)
      mode_r == startup_pkg::M_TIME |=> mode_r == startup_pkg::M_TIME;
  endproperty
  a_time: assert property (p_time) else $error("left time"); // [RQ8]
  property p_trk;
    @(posedge mclk) disable iff (!resetn)
      sv_tracked <= startup_pkg::MAX_TRACKED;
  endproperty
  a_trk: assert property (p_trk) else $error("too many"); // [RQ9]
  property p_start;
    @(posedge mclk) disable iff (!resetn)
      mode_r == startup_pkg::M_COLD && survey_go
      |=> mode_r == startup_pkg::M_SURVEY;
  endproperty
  a_start: assert property (p_start) else $error("no survey"); // [RQ7]
  property p_rej;
    @(posedge mclk) disable iff (!resetn)
      cfg_write && ready_r && !chk_ok |=> cfg_reject && $stable(sys_enabled);
  endproperty
  a_rej: assert property (p_rej) else $error("bad cfg taken"); // [RQ10]
  property p_pps;
    @(posedge mclk) disable iff (!resetn)
      $rose(pps_aligned) |-> $past(sv_tracked) >= startup_pkg::SV_PPS_ALIGN;
  endproperty
  a_pps: assert property (p_pps) else $error("pps early"); // [RQ17]
  property p_conv;
    @(posedge mclk) disable iff (!resetn)
      1'b1 |=> utc_s == $past(sys_time_s) - {24'h000000, $past(leap_r)};
  endproperty
  a_conv: assert property (p_conv) else $error("utc wrong"); // [RQ13]
  c_survey: cover property (@(posedge mclk) mode_r == startup_pkg::M_SURVEY);
  c_time: cover property (@(posedge mclk) mode_r == startup_pkg::M_TIME);
  c_rej: cover property (@(posedge mclk) cfg_reject);
  property p_susp;
    @(posedge mclk) disable iff (!resetn)
      mode_r == startup_pkg::M_SURVEY && sv_tracked < need_sv
      |=> mode_r == startup_pkg::M_SUSPEND;
  endproperty
  a_susp: assert property (p_susp) else $error("no suspend"); // [RQ16]
  c_susp: cover property (@(posedge mclk) mode_r == startup_pkg::M_SUSPEND);
  c_pps: cover property (@(posedge mclk) $rose(pps_aligned));
endmodule // startup_mode_ctrl

// [tb/host_model.sv]
`timescale 1ns/1ps
// Host side of the command link
module host_model #(
  parameter int WAIT_CYC = 22
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Requests from the bench
  input wire logic send,
  input wire logic early,
  // Command strobe
  output logic cmd_valid
);
  int cnt_r;
  // Waits out the holdoff; early lets a scenario break it on purpose
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_r <= 0;
      cmd_valid <= 1'b0;
    end else begin
      if (cnt_r < WAIT_CYC)
        cnt_r <= cnt_r + 1;
      cmd_valid <= send && (early || cnt_r >= WAIT_CYC);
    end
  end
endmodule // host_model

// [tb/startup_mode_ctrl_tb.sv]
`timescale 1ns/1ps
module startup_mode_ctrl_tb;
  logic mclk, resetn, send, early, cmd_valid, cmd_accept, cmd_ready;
  logic cfg_write, dual_band, cfg_reject, masks_ok, ephem_ok, pos_stored;
  logic fix_valid, leap_rx, utc_valid, status_pulse, almanac_done;
  logic pps_aligned, exp_dual, ok, m;
  logic [5:0] sys_req, l5_req, sys_enabled, exp_sys, s, l;
  logic [6:0] sv_visible, sv_tracked, v;
  logic [15:0] pos_moved_m, survey_fixes;
  logic [7:0] leap_s;
  logic [31:0] sys_time_s, utc_s;
  logic [2:0] mode_code;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 23;
  int k;
  logic [5:0] corner [15] = '{6'h20, 6'h21, 6'h2F, 6'h0F, 6'h07, 6'h03,
    6'h05, 6'h09, 6'h11, 6'h02, 6'h04, 6'h08, 6'h10, 6'h00, 6'h23};
  logic [6:0] pv [4] = '{7'h01, 7'h00, 7'h01, 7'h02};
  logic [3:0] pe = 4'h9;

  // Short counts keep the run brief
  startup_mode_ctrl #(.HOLDOFF_CYC(20), .ALMANAC_CYC(50), .STATUS_CYC(10))
    startup_mode_ctrl_i (.mclk(mclk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_accept(cmd_accept), .cmd_ready(cmd_ready),
    .cfg_write(cfg_write), .sys_req(sys_req), .l5_req(l5_req),
    .sys_enabled(sys_enabled), .dual_band(dual_band),
    .cfg_reject(cfg_reject), .sv_visible(sv_visible), .masks_ok(masks_ok),
    .ephem_ok(ephem_ok), .pos_stored(pos_stored),
    .pos_moved_m(pos_moved_m), .fix_valid(fix_valid), .leap_rx(leap_rx),
    .leap_s(leap_s), .survey_fixes(survey_fixes),
    .sys_time_s(sys_time_s), .utc_s(utc_s), .utc_valid(utc_valid),
    .sv_tracked(sv_tracked), .status_pulse(status_pulse),
    .almanac_done(almanac_done), .pps_aligned(pps_aligned),
    .mode_code(mode_code));

  host_model #(.WAIT_CYC(22)) host_model_i (.mclk(mclk), .resetn(resetn),
    .send(send), .early(early), .cmd_valid(cmd_valid));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task go(int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Accepted sets: single, GPS plus one, four-system mix; QZSS needs GPS
  function automatic logic cfg_ok(logic [5:0] r);
    logic [4:0] c;
    c = r[4:0];
    if (r[5] && (!r[0] || c == 5'h0F))
      return 1'b0;
    return $countones(c) == 1 || (c[0] && $countones(c) == 2) || c == 5'h0F;
  endfunction

  // One command through the host; the answer lands two edges later
  task cmd(logic e, logic exp);
    go(1);
    early <= e;
    send <= 1'b1;
    go(1);
    send <= 1'b0;
    go(1);
    #1 chk("cmd_accept", cmd_accept, exp);
  endtask

  task fix();
    go(1);
    fix_valid <= 1'b1;
    go(1);
    fix_valid <= 1'b0;
  endtask

  // Watchdog, far beyond the expected run length
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end

  // Main sequence
  initial begin
    resetn = 1'b0; send = 1'b0; early = 1'b0; cfg_write = 1'b0;
    sys_req = 6'h00; l5_req = 6'h00; sv_visible = 7'h06; masks_ok = 1'b1;
    ephem_ok = 1'b0; pos_stored = 1'b1; pos_moved_m = 16'h0000;
    fix_valid = 1'b0; leap_rx = 1'b0; leap_s = 8'h14;
    survey_fixes = 16'h0003; sys_time_s = 32'h12345678;
    exp_sys = 6'h0F; exp_dual = 1'b1;
    go(16);
    #1 chk("sys_enabled", sys_enabled, 6'h0F);
    chk("dual_band", dual_band, 1'b1);
    chk("mode_code", mode_code, startup_pkg::ST_COLD);
    go(1);
    resetn <= 1'b1;
    cmd(1'b1, 1'b0);
    chk("cmd_ready", cmd_ready, 1'b0);
    go(1);
    leap_rx <= 1'b1;
    go(1);
    leap_rx <= 1'b0;
    go(3);
    #1 chk("utc_valid", utc_valid, 1'b0);
    chk("utc_s", utc_s, 32'h12345666);
    k = 0;
    repeat (30) begin
      go(1);
      #1 k += status_pulse;
    end
    chk("status_pulses", k, 3);
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      go(1);
      #1 k++;
    end
    chk("cmd_ready", cmd_ready, 1'b1);
    cmd(1'b0, 1'b1);
    k = 0;
    while (almanac_done !== 1'b1 && k < 100) begin
      go(1);
      #1 k++;
    end
    chk("almanac_done", almanac_done, 1'b1);
    go(1);
    leap_rx <= 1'b1;
    go(1);
    leap_rx <= 1'b0;
    go(2);
    #1 chk("utc_valid", utc_valid, 1'b1);
    chk("utc_s", utc_s, 32'h12345664);
    repeat (4) begin
      go(1);
      sys_time_s <= $random(seed);
      go(2);
      #1 chk("utc_s", utc_s, sys_time_s - 32'h14);
    end
    for (int i = 0; i < 35; i++) begin
      go(1);
      s = i < 15 ? corner[i] : 6'($random(seed));
      l = 6'($random(seed)) & s & 6'h2B;
      ok = cfg_ok(s);
      sys_req <= s;
      l5_req <= l;
      cfg_write <= 1'b1;
      if (ok) begin
        exp_sys = s;
        exp_dual = |l;
      end
      go(1);
      cfg_write <= 1'b0;
      #1 chk("cfg_reject", cfg_reject, !ok);
      chk("sys_enabled", sys_enabled, exp_sys);
      chk("dual_band", dual_band, exp_dual);
    end
    go(1);
    ephem_ok <= 1'b1;
    pos_moved_m <= 16'h0064;
    go(4);
    #1 chk("mode_code", mode_code, startup_pkg::ST_COLD);
    go(1);
    pos_moved_m <= 16'h0065;
    go(4);
    #1 chk("mode_code", mode_code, startup_pkg::ST_SURVEY);
    go(1);
    sv_visible <= 7'h04;
    go(4);
    #1 chk("mode_code", mode_code, startup_pkg::ST_SUSPEND);
    go(1);
    sv_visible <= 7'h05;
    go(4);
    #1 chk("mode_code", mode_code, startup_pkg::ST_SURVEY);
    fix();
    go(1);
    sv_visible <= 7'h04;
    go(4);
    #1 chk("mode_code", mode_code, startup_pkg::ST_SURVEY);
    fix();
    fix();
    go(4);
    #1 chk("mode_code", mode_code, startup_pkg::ST_TIME_ONLY);
    chk("pps_aligned", pps_aligned, 1'b1);
    for (int i = 0; i < 4; i++) begin
      go(1);
      sv_visible <= pv[i];
      go(4);
      #1 chk("pps_aligned", pps_aligned, pe[i]);
    end
    chk("mode_code", mode_code, startup_pkg::ST_TIME_ONLY);
    for (int i = 0; i < 8; i++) begin
      go(1);
      v = i == 0 ? 7'h4E : i == 1 ? 7'h4F : 7'($random(seed));
      m = i < 2 || 1'($random(seed));
      sv_visible <= v;
      masks_ok <= m;
      go(2);
      #1 chk("sv_tracked", sv_tracked,
        !m ? 7'h00 : v > startup_pkg::MAX_TRACKED ? 7'h4E : v);
    end
    finish_test();
  end
endmodule // startup_mode_ctrl_tb
